// *** flag_update.v ***
// Purpose: single-flag set or clear on the flag register image
// Assumes: sel_i selects bit 0 to 7 of the flag register
// Notes: combinational, shared by the flag_raise and flag_lower paths
module flag_update (
  input wire [15:0] flag_i,
  input wire [2:0] sel_i,
  input wire value_i,
  output reg [15:0] flag_o
);
  integer k;
  always @*
  begin
    flag_o = flag_i;
    for (k = 0; k < 8; k = k + 1)
    begin
      if (sel_i == k[2:0])
      begin
        flag_o[k] = value_i;
      end
    end
  end
endmodule // flag_update

// *** sysctl_chk.sv ***
// Purpose: port checks for the system-control executor
// Assumes: codes from sysctl_defines.vh
// Notes: bound at the foot of this file
`include "sysctl_defines.vh"
module sysctl_chk (
  input logic mclk_i,
  input logic rstn_i,
  input logic op_valid_i,
  input logic [4:0] op_i,
  input logic [2:0] cr_sel_i,
  input logic [19:0] imm_i,
  input logic irq_i,
  input logic busy_o,
  input logic done_o,
  input logic illegal_o,
  input logic [15:0] flag_o,
  input logic trap_o,
  input logic [5:0] trap_vec_o,
  input logic mem_wr_o,
  input logic halted_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic [19:0] imm_q;
  logic [15:0] flag_q;
  logic [2:0] cr_q;
  logic [4:0] op;
  // only a taken request counts, so ops offered while busy are ignored
  assign op = (op_valid_i && !busy_o) ? op_i : `OP_NOP;
  always_ff @(posedge mclk_i)
  begin
    imm_q <= imm_i;
    flag_q <= flag_o;
    cr_q <= cr_sel_i;
  end
  property p_pc;
    (op == `OP_CTRL_REG_PUSH || op == `OP_CTRL_REG_POP) && cr_sel_i == `CR_PC
      |=> illegal_o && done_o && !mem_wr_o;
  endproperty
  a_pc: assert property (p_pc) else $error("pc select not refused");
  property p_ovf;
    op == `OP_OVERFLOW_TRAP && flag_o[`FLAG_O] |=> trap_o && trap_vec_o == `VEC_OVERFLOW;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow trap missing");
  property p_und;
    op == `OP_ILLEGAL_OP_TRAP |=> trap_o && trap_vec_o == `VEC_UNDEF
      && (flag_o & `TRAP_CLR_MASK) == 16'h0000;
  endproperty
  a_und: assert property (p_und) else $error("undefined trap wrong");
  property p_int;
    op == `OP_SOFT_TRAP |=> trap_o && trap_vec_o == imm_q[5:0];
  endproperty
  a_int: assert property (p_int) else $error("soft trap vector wrong");
  property p_ipl;
    op == `OP_PRIORITY_LEVEL_SET |=> flag_o[14:12] == imm_q[2:0];
  endproperty
  a_ipl: assert property (p_ipl) else $error("priority level wrong");
  property p_set;
    op == `OP_FLAG_RAISE |=> flag_o == (flag_q | (16'h0001 << cr_q));
  endproperty
  a_set: assert property (p_set) else $error("flag raise wrong");
  property p_pop;
    op == `OP_CTRL_REG_POP && cr_sel_i != `CR_PC |=> busy_o && !done_o ##1 done_o;
  endproperty
  a_pop: assert property (p_pop) else $error("pop timing wrong");
  property p_halt;
    halted_o && !irq_i |=> halted_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt left early");
  c_trap: cover property (trap_o);
  c_ill: cover property (illegal_o);
  c_halt: cover property ($rose(halted_o));
endmodule // sysctl_chk
bind system_control_instructions sysctl_chk sysctl_chk_inst (.mclk_i(mclk_i),
  .rstn_i(rstn_i), .op_valid_i(op_valid_i), .op_i(op_i), .cr_sel_i(cr_sel_i),
  .imm_i(imm_i), .irq_i(irq_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
  .flag_o(flag_o), .trap_o(trap_o), .trap_vec_o(trap_vec_o), .mem_wr_o(mem_wr_o),
  .halted_o(halted_o));

// *** sysctl_defines.vh ***
// Purpose: constants for the system-control instruction executor
// Assumes: 16-bit core, 20-bit addresses, opcodes are this block's own encoding
// Notes: included by the executor, its checker and the testbench
`ifndef SYSCTL_DEFINES_VH
`define SYSCTL_DEFINES_VH
// operation codes on op_i
`define OP_NOP 5'h00
`define OP_BREAK_TRAP 5'h01
`define OP_FRAME_BUILD 5'h02
`define OP_FRAME_RELEASE_RETURN 5'h03
`define OP_FLAG_LOWER 5'h04
`define OP_FLAG_RAISE 5'h05
`define OP_SOFT_TRAP 5'h06
`define OP_OVERFLOW_TRAP 5'h07
`define OP_CTRL_REG_LOAD 5'h08
`define OP_TASK_CONTEXT_RESTORE 5'h09
`define OP_VECTOR_TABLE_BASE_SET 5'h0a
`define OP_PRIORITY_LEVEL_SET 5'h0b
`define OP_CTRL_REG_POP 5'h0c
`define OP_CTRL_REG_PUSH 5'h0d
`define OP_TRAP_RETURN 5'h0e
`define OP_CTRL_REG_STORE 5'h0f
`define OP_TASK_CONTEXT_SAVE 5'h10
`define OP_ILLEGAL_OP_TRAP 5'h11
`define OP_HALT 5'h12
// control register selectors
`define CR_FLAG 3'h0
`define CR_ISP 3'h1
`define CR_USP 3'h2
`define CR_SB 3'h3
`define CR_FB 3'h4
`define CR_VTB_LO 3'h5
`define CR_VTB_HI 3'h6
`define CR_PC 3'h7
// flag register fields
`define FLAG_C 0
`define FLAG_D 1
`define FLAG_Z 2
`define FLAG_S 3
`define FLAG_B 4
`define FLAG_O 5
`define FLAG_I 6
`define FLAG_U 7
`define FLAG_IPL_LSB 12
`define FLAG_IPL_MSB 14
// reset values
`define FLAG_RST 16'h0000
`define SP_RST 16'h0000
`define VTB_RST 20'h0_0000
// fixed trap vectors
`define VEC_BREAK 6'h00
`define VEC_UNDEF 6'h01
`define VEC_OVERFLOW 6'h02
// trap clears stack-select, interrupt-enable and debug flags
`define TRAP_CLR_MASK 16'h00c2
`endif

// *** system_control_instructions.v ***
// Purpose: executes the system-control instruction group of the core
// Assumes: decode presents op_i with operands while op_valid_i; stack port answers in one cycle
// Notes: stack words are 16 bit; task context is eight words from dest_addr_i
`include "sysctl_defines.vh"
module system_control_instructions (
  input wire mclk_i,
  input wire rstn_i,
  input wire op_valid_i,
  input wire [4:0] op_i,
  input wire [2:0] cr_sel_i,
  input wire [19:0] imm_i,
  input wire [15:0] src_i,
  input wire [19:0] dest_addr_i,
  input wire [15:0] ctx_data_i,
  input wire [15:0] stack_rdata_i,
  input wire irq_i,
  output reg busy_o,
  output reg done_o,
  output reg illegal_o,
  output reg [15:0] flag_o,
  output reg [15:0] isp_o,
  output reg [15:0] usp_o,
  output reg [15:0] sb_o,
  output reg [15:0] fb_o,
  output reg [19:0] vtb_o,
  output reg trap_o,
  output reg [5:0] trap_vec_o,
  output reg [15:0] trap_flag_o,
  output reg ret_o,
  output reg [15:0] ret_pc_o,
  output reg mem_wr_o,
  output reg mem_rd_o,
  output reg [19:0] mem_addr_o,
  output reg [15:0] mem_wdata_o,
  output reg [2:0] ctx_idx_o,
  output reg ctx_load_o,
  output reg [15:0] ctx_wdata_o,
  output reg halted_o
);
  localparam S_IDLE = 3'd0;
  localparam S_POP1 = 3'd1;
  localparam S_POP2 = 3'd2;
  localparam S_CTX = 3'd3;
  localparam S_HALT = 3'd4;
  localparam S_CTX_LAST = 3'd5;
  reg [2:0] state_q;
  reg [4:0] cur_op_q;
  reg [2:0] cnt_q;
  reg [19:0] ctx_base_q;
  reg [15:0] tmp_q;
  wire [15:0] flag_upd;
  wire sp_sel = flag_o[`FLAG_U];
  wire [15:0] sp_cur = sp_sel ? usp_o : isp_o;
  reg [15:0] cr_val;
  flag_update u_flag_update (
    .flag_i(flag_o),
    .sel_i(cr_sel_i),
    .value_i(op_i == `OP_FLAG_RAISE),
    .flag_o(flag_upd)
  );
  always @*
  begin
    cr_val = 16'h0000;
    if (cr_sel_i == `CR_FLAG)
      cr_val = flag_o;
    else if (cr_sel_i == `CR_ISP)
      cr_val = isp_o;
    else if (cr_sel_i == `CR_USP)
      cr_val = usp_o;
    else if (cr_sel_i == `CR_SB)
      cr_val = sb_o;
    else if (cr_sel_i == `CR_FB)
      cr_val = fb_o;
    else if (cr_sel_i == `CR_VTB_LO)
      cr_val = vtb_o[15:0];
    else if (cr_sel_i == `CR_VTB_HI)
      cr_val = {12'h000, vtb_o[19:16]};
  end
  task set_sp;
    input [15:0] v;
    begin
      if (sp_sel)
        usp_o <= v;
      else
        isp_o <= v;
    end
  endtask
  task write_cr;
    input [15:0] v;
    begin
      if (cr_sel_i == `CR_FLAG)
        flag_o <= v;
      else if (cr_sel_i == `CR_ISP)
        isp_o <= v;
      else if (cr_sel_i == `CR_USP)
        usp_o <= v;
      else if (cr_sel_i == `CR_SB)
        sb_o <= v;
      else if (cr_sel_i == `CR_FB)
        fb_o <= v;
      else if (cr_sel_i == `CR_VTB_LO)
        vtb_o[15:0] <= v;
      else if (cr_sel_i == `CR_VTB_HI)
        vtb_o[19:16] <= v[3:0];
    end
  endtask
  task raise_trap;
    input [5:0] vec;
    begin
      trap_o <= 1'b1;
      trap_vec_o <= vec;
      trap_flag_o <= flag_o;
      flag_o <= flag_o & ~`TRAP_CLR_MASK;
    end
  endtask
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      state_q <= S_IDLE;
      cur_op_q <= `OP_NOP;
      cnt_q <= 3'd0;
      ctx_base_q <= 20'h0_0000;
      tmp_q <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      flag_o <= `FLAG_RST;
      isp_o <= `SP_RST;
      usp_o <= `SP_RST;
      sb_o <= 16'h0000;
      fb_o <= 16'h0000;
      vtb_o <= `VTB_RST;
      trap_o <= 1'b0;
      trap_vec_o <= 6'h00;
      trap_flag_o <= 16'h0000;
      ret_o <= 1'b0;
      ret_pc_o <= 16'h0000;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_addr_o <= 20'h0_0000;
      mem_wdata_o <= 16'h0000;
      ctx_idx_o <= 3'd0;
      ctx_load_o <= 1'b0;
      ctx_wdata_o <= 16'h0000;
      halted_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      trap_o <= 1'b0;
      ret_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
      ctx_load_o <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (op_valid_i)
          begin
            cur_op_q <= op_i;
            done_o <= 1'b1;
            if ((op_i == `OP_CTRL_REG_LOAD || op_i == `OP_CTRL_REG_STORE ||
                 op_i == `OP_CTRL_REG_PUSH || op_i == `OP_CTRL_REG_POP) &&
                cr_sel_i == `CR_PC)
            begin
              illegal_o <= 1'b1;
            end
            else if (op_i == `OP_BREAK_TRAP)
              raise_trap(`VEC_BREAK);
            else if (op_i == `OP_SOFT_TRAP)
              raise_trap(imm_i[5:0]);
            else if (op_i == `OP_ILLEGAL_OP_TRAP)
              raise_trap(`VEC_UNDEF);
            else if (op_i == `OP_OVERFLOW_TRAP)
            begin
              if (flag_o[`FLAG_O])
                raise_trap(`VEC_OVERFLOW);
            end
            else if (op_i == `OP_FLAG_RAISE || op_i == `OP_FLAG_LOWER)
              flag_o <= flag_upd;
            else if (op_i == `OP_CTRL_REG_LOAD)
              write_cr(src_i);
            else if (op_i == `OP_VECTOR_TABLE_BASE_SET)
              vtb_o <= imm_i;
            else if (op_i == `OP_PRIORITY_LEVEL_SET)
              flag_o[`FLAG_IPL_MSB:`FLAG_IPL_LSB] <= imm_i[2:0];
            else if (op_i == `OP_CTRL_REG_STORE)
            begin
              mem_wr_o <= 1'b1;
              mem_addr_o <= dest_addr_i;
              mem_wdata_o <= cr_val;
            end
            else if (op_i == `OP_CTRL_REG_PUSH)
            begin
              mem_wr_o <= 1'b1;
              mem_addr_o <= {4'h0, sp_cur - 16'h0002};
              mem_wdata_o <= cr_val;
              set_sp(sp_cur - 16'h0002);
            end
            else if (op_i == `OP_FRAME_BUILD)
            begin
              mem_wr_o <= 1'b1;
              mem_addr_o <= {4'h0, sp_cur - 16'h0002};
              mem_wdata_o <= fb_o;
              fb_o <= sp_cur - 16'h0002;
              set_sp(sp_cur - 16'h0002 - {8'h00, imm_i[7:0]});
            end
            else if (op_i == `OP_CTRL_REG_POP || op_i == `OP_TRAP_RETURN)
            begin
              mem_rd_o <= 1'b1;
              mem_addr_o <= {4'h0, sp_cur};
              set_sp(sp_cur + 16'h0002);
              done_o <= 1'b0;
              busy_o <= 1'b1;
              state_q <= S_POP1;
            end
            else if (op_i == `OP_FRAME_RELEASE_RETURN)
            begin
              mem_rd_o <= 1'b1;
              mem_addr_o <= {4'h0, fb_o};
              set_sp(fb_o + 16'h0002);
              done_o <= 1'b0;
              busy_o <= 1'b1;
              state_q <= S_POP1;
            end
            else if (op_i == `OP_TASK_CONTEXT_SAVE || op_i == `OP_TASK_CONTEXT_RESTORE)
            begin
              ctx_base_q <= dest_addr_i;
              cnt_q <= 3'd0;
              ctx_idx_o <= 3'd0;
              done_o <= 1'b0;
              busy_o <= 1'b1;
              state_q <= S_CTX;
            end
            else if (op_i == `OP_HALT)
            begin
              halted_o <= 1'b1;
              busy_o <= 1'b1;
              done_o <= 1'b0;
              state_q <= S_HALT;
            end
          end
        end
        S_POP1:
        begin
          tmp_q <= stack_rdata_i;
          if (cur_op_q == `OP_CTRL_REG_POP)
          begin
            write_cr(stack_rdata_i);
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state_q <= S_IDLE;
          end
          else
          begin
            if (cur_op_q == `OP_FRAME_RELEASE_RETURN)
              fb_o <= stack_rdata_i;
            else
              ret_pc_o <= stack_rdata_i;
            mem_rd_o <= 1'b1;
            mem_addr_o <= {4'h0, sp_cur};
            set_sp(sp_cur + 16'h0002);
            state_q <= S_POP2;
          end
        end
        S_POP2:
        begin
          if (cur_op_q == `OP_TRAP_RETURN)
            flag_o <= stack_rdata_i;
          else
            ret_pc_o <= stack_rdata_i;
          ret_o <= 1'b1;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          state_q <= S_IDLE;
        end
        S_CTX:
        begin
          // save shows the next index so ctx_data_i is ready a cycle ahead;
          // restore names the word whose read data has just come back
          if (cur_op_q == `OP_TASK_CONTEXT_SAVE)
            ctx_idx_o <= cnt_q + 3'd1;
          else
            ctx_idx_o <= cnt_q - 3'd1;
          mem_addr_o <= ctx_base_q + {16'h0000, cnt_q, 1'b0};
          if (cur_op_q == `OP_TASK_CONTEXT_SAVE)
          begin
            mem_wr_o <= 1'b1;
            mem_wdata_o <= ctx_data_i;
          end
          else
          begin
            mem_rd_o <= 1'b1;
          end
          if (cnt_q != 3'd0 && cur_op_q == `OP_TASK_CONTEXT_RESTORE)
          begin
            ctx_load_o <= 1'b1;
            ctx_wdata_o <= stack_rdata_i;
          end
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q == 3'd7)
          begin
            state_q <= (cur_op_q == `OP_TASK_CONTEXT_RESTORE) ? S_CTX_LAST : S_IDLE;
            busy_o <= (cur_op_q == `OP_TASK_CONTEXT_RESTORE);
            done_o <= (cur_op_q != `OP_TASK_CONTEXT_RESTORE);
          end
        end
        S_HALT:
        begin
          if (irq_i)
          begin
            halted_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_CTX_LAST:
        begin
          // last restore word lands here
          ctx_idx_o <= 3'd7;
          ctx_load_o <= 1'b1;
          ctx_wdata_o <= stack_rdata_i;
          busy_o <= 1'b0;
          done_o <= 1'b1;
          state_q <= S_IDLE;
        end
        default:
        begin
          busy_o <= 1'b0;
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // system_control_instructions

// *** testbench.sv ***
// Purpose: directed bench for the system-control executor
// Assumes: codes from sysctl_defines.vh, done_o marks completion
// Notes: stack read data follows the address, context data follows the index
`include "sysctl_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rstn_i, op_valid_i, irq_i;
  logic [4:0] op_i;
  logic [2:0] cr_sel_i, ctx_idx_o;
  logic [19:0] imm_i, dest_addr_i, vtb_o, mem_addr_o, wr_addr;
  logic [15:0] src_i, ctx_data_i, stack_rdata_i, flag_o, isp_o, usp_o, sb_o, fb_o;
  logic [15:0] trap_flag_o, ret_pc_o, mem_wdata_o, ctx_wdata_o, wr_data, tflag, rpc;
  logic busy_o, done_o, illegal_o, trap_o, ret_o, mem_wr_o, mem_rd_o, ctx_load_o, halted_o;
  logic [5:0] trap_vec_o, vec;
  logic [15:0] rd_base;
  logic [15:0] wr_log [8];
  logic [15:0] ld_log [8];
  int fails, comparisons, n_done, n_trap, n_ill;
  system_control_instructions system_control_instructions_inst (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .op_valid_i(op_valid_i), .op_i(op_i), .cr_sel_i(cr_sel_i),
    .imm_i(imm_i), .src_i(src_i), .dest_addr_i(dest_addr_i), .ctx_data_i(ctx_data_i),
    .stack_rdata_i(stack_rdata_i), .irq_i(irq_i), .busy_o(busy_o), .done_o(done_o),
    .illegal_o(illegal_o), .flag_o(flag_o), .isp_o(isp_o), .usp_o(usp_o), .sb_o(sb_o),
    .fb_o(fb_o), .vtb_o(vtb_o), .trap_o(trap_o), .trap_vec_o(trap_vec_o),
    .trap_flag_o(trap_flag_o), .ret_o(ret_o), .ret_pc_o(ret_pc_o), .mem_wr_o(mem_wr_o),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .ctx_idx_o(ctx_idx_o), .ctx_load_o(ctx_load_o), .ctx_wdata_o(ctx_wdata_o),
    .halted_o(halted_o));
  // read data depends on the address so misplaced words show up
  assign stack_rdata_i = rd_base + {11'h000, mem_addr_o[4:0]};
  assign ctx_data_i = {13'h01a5, ctx_idx_o};
  // pulses are caught here so tasks may look after the edge has passed
  always @(posedge mclk_i)
  begin
    n_done <= n_done + done_o;
    n_trap <= n_trap + trap_o;
    n_ill <= n_ill + illegal_o;
    if (trap_o)
      {vec, tflag} <= {trap_vec_o, trap_flag_o};
    if (mem_wr_o)
      {wr_addr, wr_data} <= {mem_addr_o, mem_wdata_o};
    if (ret_o)
      rpc <= ret_pc_o;
    if (mem_wr_o)
      wr_log[mem_addr_o[3:1]] <= mem_wdata_o;
    if (ctx_load_o)
      ld_log[ctx_idx_o] <= ctx_wdata_o;
  end
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic issue(input logic [4:0] op, input logic [2:0] cr, input logic [19:0] imm,
    input logic [15:0] src);
    int s;
    s = n_done;
    @(negedge mclk_i);
    op_i = op;
    cr_sel_i = cr;
    imm_i = imm;
    src_i = src;
    op_valid_i = 1'b1;
    @(negedge mclk_i);
    op_valid_i = 1'b0;
    for (int k = 0; k < 60 && n_done == s; k++)
      @(negedge mclk_i);
    chk("done", 20'h0_0001, 20'(n_done - s));
  endtask
  task automatic t_ld_push();
    issue(`OP_CTRL_REG_LOAD, `CR_ISP, 20'h0_0000, 16'h1000);
    chk("isp", 20'h0_1000, {4'h0, isp_o});
    chk("flag", 20'h0_0000, {4'h0, flag_o});
    issue(`OP_CTRL_REG_LOAD, `CR_FLAG, 20'h0_0000, 16'h0020);
    chk("flag", 20'h0_0020, {4'h0, flag_o});
    issue(`OP_CTRL_REG_PUSH, `CR_FLAG, 20'h0_0000, 16'h0000);
    chk("push addr", 20'h0_0ffe, wr_addr);
    chk("push data", 20'h0_0020, {4'h0, wr_data});
    chk("flag", 20'h0_0020, {4'h0, flag_o});
  endtask
  task automatic t_ovf();
    int n;
    issue(`OP_OVERFLOW_TRAP, 3'h0, 20'h0_0000, 16'h0000);
    chk("ovf vec", {14'h0, `VEC_OVERFLOW}, {14'h0, vec});
    issue(`OP_FLAG_LOWER, 3'h5, 20'h0_0000, 16'h0000);
    chk("flag", 20'h0_0000, {4'h0, flag_o});
    n = n_trap;
    issue(`OP_OVERFLOW_TRAP, 3'h0, 20'h0_0000, 16'h0000);
    chk("no trap", 20'h0_0000, 20'(n_trap - n));
  endtask
  task automatic t_traps();
    issue(`OP_CTRL_REG_LOAD, `CR_FLAG, 20'h0_0000, 16'h00ce);
    issue(`OP_ILLEGAL_OP_TRAP, 3'h0, 20'h0_0000, 16'h0000);
    chk("und vec", {14'h0, `VEC_UNDEF}, {14'h0, vec});
    chk("und flag", 20'h0_000c, {4'h0, flag_o});
    chk("saved flag", 20'h0_00ce, {4'h0, tflag});
    issue(`OP_FLAG_RAISE, 3'h6, 20'h0_0000, 16'h0000);
    chk("flag", 20'h0_004c, {4'h0, flag_o});
    issue(`OP_SOFT_TRAP, 3'h0, 20'h0_003f, 16'h0000);
    chk("int vec", 20'h0_003f, {14'h0, vec});
    chk("int flag", 20'h0_000c, {4'h0, flag_o});
  endtask
  task automatic t_pc();
    logic [4:0] ops [4] = '{`OP_CTRL_REG_LOAD, `OP_CTRL_REG_STORE, `OP_CTRL_REG_PUSH,
      `OP_CTRL_REG_POP};
    int n;
    foreach (ops[i])
    begin
      n = n_ill;
      issue(ops[i], `CR_PC, 20'h0_0000, 16'hffff);
      chk("illegal", 20'h0_0001, 20'(n_ill - n));
    end
    chk("isp kept", 20'h0_0ffe, {4'h0, isp_o});
  endtask
  task automatic t_misc();
    issue(`OP_VECTOR_TABLE_BASE_SET, 3'h0, 20'ha_bcde, 16'h0000);
    chk("vtb", 20'ha_bcde, vtb_o);
    issue(`OP_PRIORITY_LEVEL_SET, 3'h0, 20'h0_0007, 16'h0000);
    chk("ipl", 20'h0_0007, {17'h0, flag_o[14:12]});
    dest_addr_i = 20'h4_5678;
    issue(`OP_CTRL_REG_STORE, `CR_ISP, 20'h0_0000, 16'h0000);
    chk("store addr", 20'h4_5678, wr_addr);
    chk("store data", 20'h0_0ffe, {4'h0, wr_data});
    rd_base = 16'h1234;
    issue(`OP_CTRL_REG_POP, `CR_SB, 20'h0_0000, 16'h0000);
    chk("pop", 20'h0_1252, {4'h0, sb_o});
    chk("pop sp", 20'h0_1000, {4'h0, isp_o});
    issue(`OP_TRAP_RETURN, 3'h0, 20'h0_0000, 16'h0000);
    chk("ret pc", 20'h0_1234, {4'h0, rpc});
    chk("ret flag", 20'h0_1236, {4'h0, flag_o});
  endtask
  task automatic t_frame_ctx();
    issue(`OP_CTRL_REG_LOAD, `CR_USP, 20'h0_0000, 16'h2000);
    issue(`OP_FLAG_RAISE, 3'h7, 20'h0_0000, 16'h0000);
    rd_base = 16'h3300;
    issue(`OP_FRAME_BUILD, 3'h0, 20'h0_0010, 16'h0000);
    chk("build addr", 20'h0_1ffe, wr_addr);
    chk("build data", 20'h0_0000, {4'h0, wr_data});
    chk("build fb", 20'h0_1ffe, {4'h0, fb_o});
    chk("build usp", 20'h0_1fee, {4'h0, usp_o});
    chk("build isp", 20'h0_1004, {4'h0, isp_o});
    issue(`OP_FRAME_RELEASE_RETURN, 3'h0, 20'h0_0000, 16'h0000);
    chk("release fb", 20'h0_331e, {4'h0, fb_o});
    chk("release usp", 20'h0_2002, {4'h0, usp_o});
    chk("release pc", 20'h0_3300, {4'h0, rpc});
    dest_addr_i = 20'h2_0040;
    issue(`OP_TASK_CONTEXT_SAVE, 3'h0, 20'h0_0000, 16'h0000);
    chk("save last addr", 20'h2_004e, wr_addr);
    for (int k = 0; k < 8; k++)
      chk("save word", 20'(16'h0d28 + k), {4'h0, wr_log[k]});
    issue(`OP_TASK_CONTEXT_RESTORE, 3'h0, 20'h0_0000, 16'h0000);
    for (int k = 0; k < 8; k++)
      chk("restore word", 20'(16'h3300 + 2 * k), {4'h0, ld_log[k]});
  endtask
  task automatic t_halt();
    fork
      issue(`OP_HALT, 3'h0, 20'h0_0000, 16'h0000);
      begin
        repeat (6) @(negedge mclk_i);
        chk("halted", 20'h0_0001, {19'h0, halted_o});
        irq_i = 1'b1;
      end
    join
    irq_i = 1'b0;
    chk("resumed", 20'h0_0000, {19'h0, halted_o});
  endtask
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial
  begin
    {rstn_i, op_valid_i, irq_i, op_i, cr_sel_i} = '0;
    {imm_i, src_i, dest_addr_i} = '0;
    rd_base = 16'ha5a5;
    repeat (2) @(negedge mclk_i);
    rstn_i = 1'b1;
    t_ld_push();
    t_ovf();
    t_traps();
    t_pc();
    t_halt();
    t_misc();
    t_frame_ctx();
    give_verdict();
  end
  // the tests need about a hundred and ten cycles; 2000 leaves ample margin
  initial
  begin
    #50000;
    fails++;
    give_verdict();
  end
endmodule // testbench
